// >>> common/cfc_pkg.sv
// Shared constants, types and register layout for CAN FD mode control.
package cfc_pkg;

  // Operating mode codes used by the requested and current mode fields.
  localparam logic [2:0] MODE_NORMAL_FD = 3'h0;
  localparam logic [2:0] MODE_SLEEP     = 3'h1;
  localparam logic [2:0] MODE_INT_LOOP  = 3'h2;
  localparam logic [2:0] MODE_LISTEN    = 3'h3;
  localparam logic [2:0] MODE_CONFIG    = 3'h4;
  localparam logic [2:0] MODE_EXT_LOOP  = 3'h5;
  localparam logic [2:0] MODE_NORMAL_20 = 3'h6;
  localparam logic [2:0] MODE_RESTRICT  = 3'h7;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CAN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OSC      = 8'h04;
  localparam logic [7:0] ADDR_PIN      = 8'h08;

  // Field positions inside the register words.
  localparam int CTL_REQ_LSB = 0;
  localparam int CTL_CUR_LSB = 4;
  localparam int CTL_CFG_LSB = 8;
  localparam int OSC_DIS_BIT = 2;
  localparam int PIN_IN_LSB  = 9;

  // Configuration-only control bits, packed as they sit in bits 15:8.
  typedef struct packed {
    logic       serr_lom;
    logic       esi_gw;
    logic       retx_limit;
    logic [1:0] wake_filter_time;
    logic       wake_en;
    logic       pxe_dis;
    logic       iso_crc;
  } cfc_can_cfg_s;

  typedef struct packed {
    logic       sof_en;
    logic [1:0] clock_output_divider;
    logic       system_clock_divide;
    logic       rsvd;
    logic       oscillator_disable;
    logic       deep_power_down_mode;
    logic       pll;
  } cfc_osc_s;

  typedef struct packed {
    logic       irq_od;
    logic       tx_od;
    logic       stby_en;
    logic [1:0] mode;
    logic [1:0] lat;
    logic [1:0] dir;
  } cfc_pin_s;

  // Reset values.
  localparam logic [2:0]   REQ_MODE_RST = MODE_CONFIG;
  localparam cfc_can_cfg_s CAN_CFG_RST  = 8'h01;
  localparam cfc_osc_s     OSC_RST      = 8'h00;
  localparam cfc_pin_s     PIN_RST      = 9'h033;

  // Timing.
  localparam int         CLK_PERIOD_NS      = 40;
  localparam int         WAKE_FILT_BASE_NS  = 320;
  localparam logic [7:0] WAKE_FILT_BASE_CYC =
    8'((WAKE_FILT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] INTEG_BITS         = 4'hb;

  typedef enum logic [1:0] {ST_CFG, ST_INTEG, ST_ON, ST_SLEEP} cfc_state_e;

  // Controls handed to the protocol engine.
  typedef struct packed {
    logic tx_enable;
    logic ack_enable;
    logic err_flag_enable;
    logic err_count_enable;
    logic wait_idle_on_err;
    logic no_ack_required;
    logic bus_on;
    logic iso_crc;
    logic pxe_enable;
    logic hard_sync;
    logic retx_limit;
    logic esi_recessive;
    logic fd_disable;
  } cfc_pe_ctl_s;

  // Status and events from the protocol engine.
  typedef struct packed {
    logic tx_bit;
    logic tx_is_ack;
    logic bus_idle;
    logic bit_tick;
    logic sof;
    logic sys_err;
    logic pxe_evt;
    logic err_passive;
  } cfc_pe_evt_s;

  function automatic logic is_loop(input logic [2:0] m);
    return (m == MODE_INT_LOOP) || (m == MODE_EXT_LOOP);
  endfunction

  function automatic logic is_debug(input logic [2:0] m);
    return is_loop(m) || (m == MODE_LISTEN) || (m == MODE_RESTRICT);
  endfunction

endpackage

// >>> hw/cfc_mode_ctrl.sv
// CAN FD mode sequencing, configuration registers and pin control.
`timescale 1ns/1ps
`default_nettype none

module cfc_mode_ctrl
  import cfc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire cfc_pe_evt_s PE_EVT,
  output cfc_pe_ctl_s      PE_CTL,
  output logic             PE_RX,
  input  wire logic        BUS_RX,
  output logic             BUS_TX_O,
  output logic             BUS_TX_OE_N,
  output logic             CLKOUT_O,
  input  wire logic [1:0]  MP_I,
  output logic      [1:0]  MP_O,
  output logic      [1:0]  MP_OE_N,
  input  wire logic [1:0]  IRQ_REQ,
  output logic             PLL_EN,
  output logic             SYS_CLK_DIV,
  output logic             OSC_DISABLE,
  output logic             WAKE
);

  cfc_state_e   state_q;
  logic [2:0]   cur_q;
  logic [2:0]   req_q;
  logic [3:0]   integ_cnt_q;
  cfc_can_cfg_s cfg_q;
  cfc_osc_s     osc_q;
  cfc_pin_s     pin_q;
  logic         tx_q;
  logic         rx_q;
  logic         rx_prev_q;
  logic [7:0]   wcnt_q;
  logic         wake_q;
  logic [4:0]   clk_cnt_q;
  logic         clk_tgl_q;
  logic         clock_output_pin_q;
  logic [31:0]  rdata_q;

  logic         cfg_ok;
  logic         wr_ctl;
  logic         wr_osc;
  logic         wr_pin;
  logic         enter_sleep;
  logic         exit_sleep;
  logic         pe_abort;
  logic         wake_evt;
  logic         rx_int;
  logic [7:0]   wake_thr;
  logic [4:0]   clk_half;

  assign cfg_ok = (state_q == ST_CFG);
  assign wr_ctl = WR && (ADDR == ADDR_CAN_CTRL);
  assign wr_osc = WR && (ADDR == ADDR_OSC);
  assign wr_pin = WR && (ADDR == ADDR_PIN);

  // An engine event in the same cycle outranks a sleep request, so the
  // oscillator flag and the pin wipe never run ahead of the sequencer.
  assign pe_abort    = (state_q == ST_ON) &&
                       (PE_EVT.sys_err || (PE_EVT.pxe_evt && !cfg_q.pxe_dis));
  assign enter_sleep = PE_EVT.bus_idle && (req_q == MODE_SLEEP) &&
                       ((state_q == ST_CFG) || (state_q == ST_ON)) &&
                       !pe_abort;

  // Loopback feeds the engine its own transmit bit and blinds it to the pin.
  assign rx_int = is_loop(cur_q) ? PE_EVT.tx_bit : BUS_RX;

  // Longer filter settings double the low time needed to count as a wake.
  assign wake_thr = 8'(WAKE_FILT_BASE_CYC << cfg_q.wake_filter_time);
  assign wake_evt = (state_q == ST_SLEEP) &&
                    (cfg_q.wake_en ? (!BUS_RX && wcnt_q == wake_thr - 8'h01)
                                   : (rx_prev_q && !BUS_RX));
  assign exit_sleep = (state_q == ST_SLEEP) && (wake_evt || !osc_q.oscillator_disable);

  // Mode sequencer.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_q     <= ST_CFG;
      cur_q       <= MODE_CONFIG;
      integ_cnt_q <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        ST_CFG:
        begin
          if (enter_sleep)
            state_q <= ST_SLEEP;
          else if (PE_EVT.bus_idle && req_q != MODE_CONFIG)
          begin
            cur_q       <= req_q;
            state_q     <= ST_INTEG;
            integ_cnt_q <= 4'h0;
          end
        end
        ST_INTEG:
        begin
          if (req_q == MODE_CONFIG)
          begin
            state_q <= ST_CFG;
            cur_q   <= MODE_CONFIG;
          end
          else if (PE_EVT.bit_tick)
          begin
            if (!rx_int)
              integ_cnt_q <= 4'h0;
            else if (integ_cnt_q == INTEG_BITS - 4'h1)
              state_q <= ST_ON;
            else
              integ_cnt_q <= integ_cnt_q + 4'h1;
          end
        end
        ST_ON:
        begin
          if (PE_EVT.sys_err)
            cur_q <= cfg_q.serr_lom ? MODE_LISTEN : MODE_RESTRICT;
          else if (PE_EVT.pxe_evt && !cfg_q.pxe_dis)
          begin
            // Counters untouched; recessive until the bus is rejoined.
            state_q     <= ST_INTEG;
            integ_cnt_q <= 4'h0;
          end
          else if (enter_sleep)
          begin
            state_q <= ST_SLEEP;
            cur_q   <= MODE_CONFIG;
          end
          else if (PE_EVT.bus_idle && req_q == MODE_CONFIG)
          begin
            state_q <= ST_CFG;
            cur_q   <= MODE_CONFIG;
          end
          // Any other differing request is held off until configuration.
        end
        ST_SLEEP:
        begin
          if (exit_sleep)
            state_q <= ST_CFG;
        end
      endcase
    end
  end

  // Control register; config-only bits are frozen outside configuration.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      req_q <= REQ_MODE_RST;
      cfg_q <= CAN_CFG_RST;
    end
    else
    begin
      if (exit_sleep)
        req_q <= MODE_CONFIG;
      else if (wr_ctl)
        req_q <= WDATA[CTL_REQ_LSB +: 3];
      if (wr_ctl && cfg_ok)
        cfg_q <= cfc_can_cfg_s'(WDATA[CTL_CFG_LSB +: 8]);
    end
  end

  // Oscillator register. Hardware set of the disable flag beats a clear.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      osc_q <= OSC_RST;
    else
    begin
      if (wr_osc && cfg_ok)
      begin
        osc_q.pll     <= WDATA[0];
        osc_q.deep_power_down_mode     <= WDATA[1];
        osc_q.system_clock_divide <= WDATA[4];
        osc_q.clock_output_divider <= WDATA[6:5];
        osc_q.sof_en  <= WDATA[7];
      end
      osc_q.rsvd <= 1'b0;
      if (enter_sleep)
        osc_q.oscillator_disable <= 1'b1;
      else if (wr_osc && !WDATA[OSC_DIS_BIT])
        osc_q.oscillator_disable <= 1'b0;
    end
  end

  // Pin register, wiped on entry to deep power-down.
  always_ff @(posedge CLK)
  begin
    if (!RST_N || (enter_sleep && osc_q.deep_power_down_mode))
      pin_q <= PIN_RST;
    else if (wr_pin)
      pin_q <= cfc_pin_s'(WDATA[8:0]);
  end

  // Bus transmit value; anything but an active mode stays recessive.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      tx_q <= 1'b1;
    else if (state_q != ST_ON)
      tx_q <= 1'b1;
    else if (cur_q == MODE_LISTEN || cur_q == MODE_INT_LOOP)
      tx_q <= 1'b1;
    else if (cur_q == MODE_RESTRICT)
      tx_q <= PE_EVT.tx_is_ack ? PE_EVT.tx_bit : 1'b1;
    else
      tx_q <= PE_EVT.tx_bit;
  end

  // Open-drain only ever pulls low; recessive releases the pin.
  assign BUS_TX_O    = pin_q.tx_od ? 1'b0 : tx_q;
  assign BUS_TX_OE_N = pin_q.tx_od ? tx_q : 1'b0;

  // Receive path and wake detection.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rx_q      <= 1'b1;
      rx_prev_q <= 1'b1;
      wcnt_q    <= 8'h00;
      wake_q    <= 1'b0;
    end
    else
    begin
      rx_q      <= rx_int;
      rx_prev_q <= BUS_RX;
      wake_q    <= wake_evt;
      if (state_q != ST_SLEEP || BUS_RX)
        wcnt_q <= 8'h00;
      else if (wcnt_q != wake_thr)
        wcnt_q <= wcnt_q + 8'h01;
    end
  end

  // Clock output: half period is 2^(divider) cycles, doubled by system_clock div.
  // The fastest output is half the input clock since it comes from a flop.
  assign clk_half = 5'(5'h01 << ({1'b0, osc_q.clock_output_divider} +
                                 {2'b00, osc_q.system_clock_divide}));

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      clk_cnt_q <= 5'h00;
      clk_tgl_q <= 1'b0;
      clock_output_pin_q    <= 1'b0;
    end
    else
    begin
      if (clk_cnt_q >= clk_half - 5'h01)
      begin
        clk_cnt_q <= 5'h00;
        clk_tgl_q <= !clk_tgl_q;
      end
      else
        clk_cnt_q <= clk_cnt_q + 5'h01;
      clock_output_pin_q <= osc_q.sof_en ? PE_EVT.sof : clk_tgl_q;
    end
  end

  assign CLKOUT_O    = clock_output_pin_q;
  assign PLL_EN      = osc_q.pll;
  assign SYS_CLK_DIV = osc_q.system_clock_divide;
  assign OSC_DISABLE = osc_q.oscillator_disable;
  assign WAKE        = wake_q;
  assign PE_RX       = rx_q;

  // Multipurpose pins: mode bit 1 is general I/O, direction bit 1 is input.
  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    logic o_q;
    logic oe_n_q;

    always_ff @(posedge CLK)
    begin
      if (!RST_N)
      begin
        o_q    <= 1'b1;
        oe_n_q <= 1'b1;
      end
      else if (i == 0 && pin_q.stby_en)
      begin
        o_q    <= (state_q == ST_SLEEP);
        oe_n_q <= 1'b0;
      end
      else if (pin_q.mode[i])
      begin
        o_q    <= pin_q.lat[i];
        oe_n_q <= pin_q.dir[i];
      end
      else if (pin_q.irq_od)
      begin
        o_q    <= 1'b0;
        oe_n_q <= !IRQ_REQ[i];
      end
      else
      begin
        o_q    <= !IRQ_REQ[i];
        oe_n_q <= 1'b0;
      end
    end

    assign MP_O[i]    = o_q;
    assign MP_OE_N[i] = oe_n_q;
  end

  // Protocol engine controls.
  always_comb
  begin
    PE_CTL                  = '0;
    PE_CTL.bus_on           = (state_q == ST_ON);
    PE_CTL.tx_enable        = PE_CTL.bus_on && cur_q != MODE_LISTEN &&
                              cur_q != MODE_RESTRICT;
    PE_CTL.ack_enable       = cur_q != MODE_LISTEN;
    PE_CTL.err_flag_enable  = cur_q != MODE_LISTEN &&
                              cur_q != MODE_RESTRICT;
    PE_CTL.err_count_enable = PE_CTL.err_flag_enable;
    PE_CTL.wait_idle_on_err = cur_q == MODE_RESTRICT;
    PE_CTL.no_ack_required  = is_loop(cur_q);
    PE_CTL.iso_crc          = cfg_q.iso_crc;
    PE_CTL.pxe_enable       = !cfg_q.pxe_dis;
    PE_CTL.hard_sync        = (state_q == ST_INTEG);
    PE_CTL.retx_limit       = cfg_q.retx_limit;
    PE_CTL.esi_recessive    = PE_EVT.err_passive || cfg_q.esi_gw;
    PE_CTL.fd_disable       = cur_q == MODE_NORMAL_20;
  end

  // Read port: data stand in the cycle after the strobe; unmapped reads 0.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      rdata_q <= 32'h0000_0000;
    else if (RD)
    begin
      if (ADDR == ADDR_CAN_CTRL)
        rdata_q <= {16'h0000, cfg_q, 1'b0, cur_q, 1'b0, req_q};
      else if (ADDR == ADDR_OSC)
        rdata_q <= {24'h00_0000, osc_q};
      else if (ADDR == ADDR_PIN)
        rdata_q <= {21'h00_0000, MP_I, pin_q};
      else
        rdata_q <= 32'h0000_0000;
    end
    else
      rdata_q <= 32'h0000_0000;
  end

  assign RDATA = rdata_q;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_listen_quiet;
    (state_q == ST_ON && cur_q == MODE_LISTEN) |=> tx_q;
  endproperty
  a_listen_quiet: assert property (p_listen_quiet)
    else $error("listen-only drove the bus");

  property p_listen_passive;
    (cur_q == MODE_LISTEN) |->
      !PE_CTL.ack_enable && !PE_CTL.err_flag_enable &&
      !PE_CTL.err_count_enable;
  endproperty
  a_listen_passive: assert property (p_listen_passive)
    else $error("listen-only left ack or error logic enabled");

  property p_restrict_recessive;
    (state_q == ST_ON && cur_q == MODE_RESTRICT && !PE_EVT.tx_is_ack)
      |=> tx_q;
  endproperty
  a_restrict_recessive: assert property (p_restrict_recessive)
    else $error("restricted mode drove a non-ack bit");

  property p_loop_rx;
    is_loop(cur_q) |=> PE_RX == $past(PE_EVT.tx_bit);
  endproperty
  a_loop_rx: assert property (p_loop_rx)
    else $error("loopback receive not taken from transmit");

  property p_ext_loop_tx;
    (state_q == ST_ON && cur_q == MODE_EXT_LOOP)
      |=> tx_q == $past(PE_EVT.tx_bit);
  endproperty
  a_ext_loop_tx: assert property (p_ext_loop_tx)
    else $error("external loopback not driving the pin");

  property p_cfg_frozen;
    (wr_ctl && !cfg_ok) |=> $stable(cfg_q);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("config bits changed outside configuration");

  property p_sleep_flag;
    enter_sleep |=> osc_q.oscillator_disable && state_q == ST_SLEEP;
  endproperty
  a_sleep_flag: assert property (p_sleep_flag)
    else $error("oscillator disable not set on sleep entry");

  property p_sys_err;
    (state_q == ST_ON && PE_EVT.sys_err) |=>
      cur_q == ($past(cfg_q.serr_lom) ? MODE_LISTEN : MODE_RESTRICT);
  endproperty
  a_sys_err: assert property (p_sys_err)
    else $error("system error took the wrong mode");

  property p_integrate;
    $rose(state_q == ST_ON) |->
      $past(state_q) == ST_INTEG && $past(integ_cnt_q) == INTEG_BITS - 4'h1;
  endproperty
  a_integrate: assert property (p_integrate)
    else $error("bus joined without eleven recessive bits");

  property p_debug_hold;
    (state_q == ST_ON && is_debug(cur_q) && is_debug(req_q) &&
     !PE_EVT.sys_err) |=> $stable(cur_q);
  endproperty
  a_debug_hold: assert property (p_debug_hold)
    else $error("direct change between debug modes");

  property p_idle_wait;
    (state_q == ST_CFG && !PE_EVT.bus_idle) |=> state_q == ST_CFG;
  endproperty
  a_idle_wait: assert property (p_idle_wait)
    else $error("mode left configuration while bus busy");

  c_listen_on: cover property (state_q == ST_ON && cur_q == MODE_LISTEN);
  c_sleep_wake: cover property (state_q == ST_SLEEP ##1 state_q == ST_CFG);
  c_sys_err: cover property (state_q == ST_ON && PE_EVT.sys_err);
  c_pxe_rejoin: cover property (state_q == ST_ON && pe_abort &&
                                !PE_EVT.sys_err);

endmodule

`default_nettype wire

// >>> tb/cfc_bus_model.sv
// Behavioural CAN bus and protocol-engine stand-in for the mode controller.
`timescale 1ns/1ps
`default_nettype none

module cfc_bus_model
  import cfc_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   tx_o,
  input  wire logic   tx_oe_n,
  input  wire logic   dom,
  input  wire logic   tx_bit,
  input  wire logic   tx_is_ack,
  input  wire logic   sys_err,
  input  wire logic   sof,
  input  wire logic   pxe,
  input  wire logic   err_passive,
  output var  logic   rx,
  output var  cfc_pe_evt_s evt
);
  logic [1:0] tick_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tick_q <= 2'h0;
    else
      tick_q <= tick_q + 2'h1;
  end

  // A released open-drain pin leaves the pulled-up bus recessive.
  assign rx = ~dom & (tx_oe_n | tx_o);

  always_comb
  begin
    evt             = '0;
    evt.tx_bit      = tx_bit;
    evt.tx_is_ack   = tx_is_ack;
    evt.bus_idle    = ~dom;
    evt.bit_tick    = (tick_q == 2'h3);
    evt.sys_err     = sys_err;
    evt.sof         = sof;
    evt.pxe_evt     = pxe;
    evt.err_passive = err_passive;
  end
endmodule

`default_nettype wire

// >>> tb/cfc_mode_ctrl_tb.sv
// Self-checking testbench for the CAN FD mode controller.
`timescale 1ns/1ps
`default_nettype none

module cfc_mode_ctrl_tb;
  import cfc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_p = 1'b0;
  logic [31:0] rdata;
  cfc_pe_evt_s evt;
  cfc_pe_ctl_s ctl;
  logic        pe_rx;
  logic        bus_rx;
  logic        tx_o;
  logic        tx_oe_n;
  logic        clkout;
  logic [1:0]  mp_i = 2'h0;
  logic [1:0]  mp_o;
  logic [1:0]  mp_oe_n;
  logic [1:0]  irq = 2'b01;
  logic        pll;
  logic        sdiv;
  logic        oscd;
  logic        wake;
  logic        dom = 1'b0;
  logic        tx_bit = 1'b1;
  logic        tx_is_ack = 1'b0;
  logic        sys_err = 1'b0;
  logic        sof = 1'b0;
  logic        pxe = 1'b0;
  logic        err_passive = 1'b0;
  logic [7:0]  cfg = 8'h01;
  logic [31:0] exp_q [$];
  logic [8:0]  pv [3] = '{9'h080, 9'h180, 9'h038};
  logic [3:0]  pe [3] = '{4'b0010, 4'b1000, 4'b0010};
  int          failures = 0;
  int          num_checks = 0;

  initial
  begin
    forever #20 clk = ~clk;
  end

  cfc_mode_ctrl DUT (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PE_EVT(evt), .PE_CTL(ctl), .PE_RX(pe_rx),
    .BUS_RX(bus_rx), .BUS_TX_O(tx_o), .BUS_TX_OE_N(tx_oe_n),
    .CLKOUT_O(clkout), .MP_I(mp_i), .MP_O(mp_o), .MP_OE_N(mp_oe_n),
    .IRQ_REQ(irq), .PLL_EN(pll), .SYS_CLK_DIV(sdiv), .OSC_DISABLE(oscd),
    .WAKE(wake)
  );

  cfc_bus_model u_bus (
    .clk(clk), .rst_n(rst_n), .tx_o(tx_o), .tx_oe_n(tx_oe_n), .dom(dom),
    .tx_bit(tx_bit), .tx_is_ack(tx_is_ack), .sys_err(sys_err), .sof(sof),
    .pxe(pxe), .err_passive(err_passive), .rx(bus_rx), .evt(evt)
  );

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // The watcher below pairs each read with the oldest expected word.
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  always @(posedge clk)
  begin
    if (rd_p && exp_q.size() > 0)
      chk("rdata", exp_q.pop_front(), rdata);
    rd_p <= rd;
  end

  function automatic logic [31:0] cw(input logic [2:0] c,
                                     input logic [2:0] r);
    return {16'h0, cfg, 1'b0, c, 1'b0, r};
  endfunction

  task automatic go(input logic [2:0] m);
    int n;
    wr_reg(ADDR_CAN_CTRL, {16'h0, cfg, 5'h0, m});
    n = 0;
    while (m != MODE_CONFIG && m != MODE_SLEEP && ctl.bus_on !== 1'b1
           && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    if (m != MODE_CONFIG && m != MODE_SLEEP)
      chk1("bus_on", 1'b1, ctl.bus_on);
  endtask

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    logic        h [6];
    logic [2:0]  m;
    int          n;
    void'($urandom(32'h516c5caf));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cfg = 8'($urandom);
    mp_i <= 2'($urandom);
    rd_reg(ADDR_CAN_CTRL, {16'h0, CAN_CFG_RST, 8'h44});
    rd_reg(ADDR_OSC, 32'h0);
    rd_reg(ADDR_PIN, {21'h0, mp_i, PIN_RST});
    rd_reg(8'h0c, 32'h0);
    wr_reg(ADDR_CAN_CTRL, {16'h0, cfg, 8'h04});
    wr_reg(ADDR_OSC, 32'h11);
    rd_reg(ADDR_CAN_CTRL, cw(MODE_CONFIG, MODE_CONFIG));
    rd_reg(ADDR_OSC, 32'h11);
    settle();
    chk1("pll", 1'b1, pll);
    chk1("sysdiv", 1'b1, sdiv);
    chk1("iso", cfg[0], ctl.iso_crc);
    chk1("pxe", ~cfg[1], ctl.pxe_enable);
    chk1("retx", cfg[5], ctl.retx_limit);
    chk1("esi", cfg[6], ctl.esi_recessive);
    @(posedge clk);
    err_passive <= 1'b1;
    settle();
    chk1("esi_p", 1'b1, ctl.esi_recessive);
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk);
      h[i] = clkout;
    end
    chk1("clkout", ~h[0], h[2]);
    chk1("clkout", ~h[1], h[3]);
    go(MODE_LISTEN);
    chk1("bus_on", 1'b1, ctl.bus_on);
    rd_reg(ADDR_CAN_CTRL, cw(MODE_LISTEN, MODE_LISTEN));
    wr_reg(ADDR_CAN_CTRL, {16'h0, ~cfg, 8'h03});
    wr_reg(ADDR_OSC, 32'h0);
    rd_reg(ADDR_CAN_CTRL, cw(MODE_LISTEN, MODE_LISTEN));
    rd_reg(ADDR_OSC, 32'h11);
    @(posedge clk);
    tx_bit <= 1'b0;
    dom <= 1'b1;
    settle();
    chk1("tx", 1'b1, tx_o);
    chk1("pe_rx", 1'b0, pe_rx);
    chk1("tx_en", 1'b0, ctl.tx_enable);
    chk1("ack", 1'b0, ctl.ack_enable);
    chk1("eflag", 1'b0, ctl.err_flag_enable);
    chk1("ecnt", 1'b0, ctl.err_count_enable);
    @(posedge clk);
    dom <= 1'b0;
    go(MODE_RESTRICT);
    rd_reg(ADDR_CAN_CTRL, cw(MODE_LISTEN, MODE_RESTRICT));
    go(MODE_CONFIG);
    go(MODE_RESTRICT);
    chk1("ack", 1'b1, ctl.ack_enable);
    chk1("tx_en", 1'b0, ctl.tx_enable);
    chk1("eflag", 1'b0, ctl.err_flag_enable);
    chk1("ecnt", 1'b0, ctl.err_count_enable);
    chk1("wait", 1'b1, ctl.wait_idle_on_err);
    @(posedge clk);
    tx_is_ack <= 1'b1;
    settle();
    chk1("tx_ack", 1'b0, tx_o);
    @(posedge clk);
    tx_is_ack <= 1'b0;
    settle();
    chk1("tx", 1'b1, tx_o);
    for (int k = 0; k < 2; k++)
    begin
      m = k[0] ? MODE_EXT_LOOP : MODE_INT_LOOP;
      @(posedge clk);
      tx_bit <= 1'b1;
      dom <= 1'b0;
      go(MODE_CONFIG);
      go(m);
      chk1("no_ack", 1'b1, ctl.no_ack_required);
      @(posedge clk);
      tx_bit <= 1'b0;
      settle();
      chk1("pe_rx", 1'b0, pe_rx);
      chk1("tx", ~k[0], tx_o);
      @(posedge clk);
      tx_bit <= 1'b1;
      dom <= 1'b1;
      settle();
      chk1("pe_rx", 1'b1, pe_rx);
    end
    @(posedge clk);
    dom <= 1'b0;
    go(MODE_CONFIG);
    go(MODE_NORMAL_FD);
    @(posedge clk);
    sys_err <= 1'b1;
    @(posedge clk);
    sys_err <= 1'b0;
    m = cfg[7] ? MODE_LISTEN : MODE_RESTRICT;
    rd_reg(ADDR_CAN_CTRL, cw(m, MODE_NORMAL_FD));
    @(posedge clk);
    pxe <= 1'b1;
    @(posedge clk);
    pxe <= 1'b0;
    settle();
    chk1("pxe_sync", ~cfg[1], ctl.hard_sync);
    go(MODE_CONFIG);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(ADDR_PIN, {23'h0, pv[i]});
      settle();
      chk("mp", {28'h0, pe[i]}, {28'h0, mp_oe_n, mp_o});
      chk1("tx_oe", pv[i][7], tx_oe_n);
      chk1("tx_od", ~pv[i][7], tx_o);
    end
    wr_reg(ADDR_OSC, 32'h91);
    @(posedge clk);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    @(negedge clk);
    chk1("sof", 1'b1, clkout);
    @(negedge clk);
    chk1("sof", 1'b0, clkout);
    wr_reg(ADDR_OSC, 32'h11);
    wr_reg(ADDR_PIN, 32'h070);
    go(MODE_SLEEP);
    settle();
    chk1("oscillator_disable", 1'b1, oscd);
    chk1("stby", 1'b1, mp_o[0]);
    chk1("stby_oe", 1'b0, mp_oe_n[0]);
    rd_reg(ADDR_OSC, 32'h15);
    rd_reg(ADDR_CAN_CTRL, cw(MODE_CONFIG, MODE_SLEEP));
    wr_reg(ADDR_OSC, 32'h11);
    repeat (3) @(negedge clk);
    chk1("oscillator_disable", 1'b0, oscd);
    chk1("stby", 1'b0, mp_o[0]);
    rd_reg(ADDR_CAN_CTRL, cw(MODE_CONFIG, MODE_CONFIG));
    wr_reg(ADDR_OSC, 32'h13);
    go(MODE_SLEEP);
    rd_reg(ADDR_PIN, {21'h0, mp_i, PIN_RST});
    chk1("lpm_pin", 1'b1, mp_oe_n[0]);
    @(posedge clk);
    dom <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk1("wake", 1'b1, wake);
    @(posedge clk);
    dom <= 1'b0;
    rd_reg(ADDR_CAN_CTRL, cw(MODE_CONFIG, MODE_CONFIG));
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule

`default_nettype wire
